// ===== rtl/asp_defines.vh
// shared constants of the serial port and conversion sequencer
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

// ==================================================
// command byte layout
`define ASP_CMD_WEN_BIT     7
`define ASP_CMD_RW_BIT      6
`define ASP_CMD_RS_HI       5
`define ASP_CMD_RS_LO       3
`define ASP_CMD_CREAD_BIT   2
`define ASP_CMD_CREAD_ENTER 8'h5C
`define ASP_CMD_CREAD_EXIT  8'h58

// ==================================================
// register select codes
`define ASP_RS_STATUS       3'h0
`define ASP_RS_MODE         3'h1
`define ASP_RS_CONFIG       3'h2
`define ASP_RS_DATA         3'h3
`define ASP_RS_ID           3'h4

// ==================================================
// register widths in bits
`define ASP_LEN_BYTE        6'h08
`define ASP_LEN_WORD        6'h18
`define ASP_LEN_WORD_STAT   6'h20

// ==================================================
// mode word fields and reset value
`define ASP_MODE_MD_HI      23
`define ASP_MODE_MD_LO      21
`define ASP_MODE_APPEND_BIT 20
`define ASP_MODE_ZLAT_BIT   15
`define ASP_MODE_NOTCH_BIT  10
`define ASP_MODE_RATE_HI    9
`define ASP_MODE_RATE_LO    0
`define ASP_MODE_RESET      24'h000060

// operating mode codes
`define ASP_MD_CONT         3'h0
`define ASP_MD_SINGLE       3'h1
`define ASP_MD_IDLE         3'h2
`define ASP_MD_PDOWN        3'h3

// ==================================================
// configuration word fields and reset value
`define ASP_CONF_CH_HI      15
`define ASP_CONF_CH_LO      8
`define ASP_CONF_RESET      24'h000100

// ==================================================
// status byte
`define ASP_STAT_RDY_BIT    7

// ==================================================
// timing
`define ASP_IFRESET_ONES    6'h28
`define ASP_STARTUP_TIME_US 1000
`define ASP_CLK_FREQ_MHZ    100
`define ASP_RATE_UNIT       1024
`define ASP_SETTLE_FACTOR   4

`endif

// ===== rtl/asp_fifo.v
// sample fifo between the filter output and the conversion sequencer
`timescale 1ns/1ns
`default_nettype none

module asp_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output reg              inReady,
  output reg  [WIDTH-1:0] outData,
  output reg              outValid,
  input  wire             outReady
);

  // pointers wrap naturally, so DEPTH must equal 2**AW
  localparam [AW:0] DEPTH_W = DEPTH;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr;
  reg  [AW-1:0]    rdPtr;
  reg  [AW:0]      count;

  wire             push      = inValid & inReady;
  wire             pop       = outValid & outReady;
  wire [AW-1:0]    nextRd    = pop ? rdPtr + {{(AW-1){1'b0}}, 1'b1} : rdPtr;
  wire [AW:0]      nextCount = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // ==================================================
  // storage
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr] <= inData;
    end
  end

  // ==================================================
  // pointers and flags
  always @(posedge clk) begin
    if (!rst_n) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      inReady  <= 1'b1;
      outValid <= 1'b0;
      outData  <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (push) begin
        wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      rdPtr    <= nextRd;
      count    <= nextCount;
      inReady  <= (nextCount != DEPTH_W);
      outValid <= (nextCount != {(AW+1){1'b0}});
      // bypass: the head word may be the one written this cycle
      if (push && (wrPtr == nextRd)) begin
        outData <= inData;
      end else begin
        outData <= mem[nextRd];
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/asp_core.v
// serial register port and conversion mode sequencer of the converter
`timescale 1ns/1ns
`default_nettype none
`include "asp_defines.vh"

module asp_core #(
  parameter        FIFO_DEPTH     = 8,
  parameter        FIFO_AW        = 3,
  parameter [31:0] STARTUP_CYCLES = `ASP_STARTUP_TIME_US * `ASP_CLK_FREQ_MHZ,
  parameter [31:0] RATE_UNIT      = `ASP_RATE_UNIT,
  parameter [7:0]  ID_CODE        = 8'h5A   // arbitrary identity value
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        csN,
  input  wire        sclk,
  input  wire        din,
  input  wire [23:0] sampleData,
  input  wire        sampleValid,
  output wire        sampleReady,
  output reg         doutRdy,
  output reg         doutOe,
  output reg  [23:0] modeWord,
  output reg  [23:0] configWord,
  output reg  [3:0]  activeChannel,
  output reg         filterReset,
  output reg         powerDown
);

  // ==================================================
  // state codes
  localparam [1:0] SP_CMD    = 2'h0;
  localparam [1:0] SP_WRITE  = 2'h1;
  localparam [1:0] SP_READ   = 2'h2;
  localparam [1:0] SP_CREAD  = 2'h3;

  localparam [2:0] CV_OFF    = 3'h0;
  localparam [2:0] CV_WAKE   = 3'h1;
  localparam [2:0] CV_SETTLE = 3'h2;
  localparam [2:0] CV_TAKE   = 3'h3;
  localparam [2:0] CV_UPD    = 3'h4;

  // ==================================================
  // pin synchronisers, stage 0 feeds only stage 1
  reg [2:0] sclkSync;
  reg [2:0] csSync;
  reg [1:0] dinSync;

  always @(posedge clk) begin
    if (!rst_n) begin
      sclkSync <= 3'h7;
      csSync   <= 3'h7;
      dinSync  <= 2'h0;
    end else if (ce) begin
      sclkSync <= {sclkSync[1:0], sclk};
      csSync   <= {csSync[1:0], csN};
      dinSync  <= {dinSync[0], din};
    end
  end

  wire csLow = ~csSync[1];
  wire csFall = ~csSync[1] & csSync[2];
  wire sRise = sclkSync[1] & ~sclkSync[2] & csLow;
  wire sFall = ~sclkSync[1] & sclkSync[2] & csLow;
  wire dinBit = dinSync[1];

  // ==================================================
  // state registers
  reg [1:0]  spState;
  reg [7:0]  cmdReg;
  reg [23:0] inShift;
  reg [5:0]  bitCnt;
  reg [31:0] outShift;
  reg [5:0]  outLen;
  reg [5:0]  outCnt;
  reg        curBit;
  reg        shifting;
  reg [5:0]  onesCnt;
  reg        ifReset;
  reg [7:0]  creadWin;
  reg        rdyN;
  reg [23:0] dataReg;
  reg [3:0]  dataChan;
  reg [2:0]  cvState;
  reg [31:0] cvCnt;
  reg [23:0] pendWord;
  reg        pendDrop;
  reg        restartReq;

  wire [2:0]  opMode    = modeWord[`ASP_MODE_MD_HI:`ASP_MODE_MD_LO];
  wire        appendSel = modeWord[`ASP_MODE_APPEND_BIT];
  wire        zeroLat   = modeWord[`ASP_MODE_ZLAT_BIT];
  wire [7:0]  chMask    = configWord[`ASP_CONF_CH_HI:`ASP_CONF_CH_LO];
  wire [31:0] fsWide    = {22'h000000, modeWord[`ASP_MODE_RATE_HI:`ASP_MODE_RATE_LO]};
  wire [31:0] oneCyc    = fsWide * RATE_UNIT;
  wire [31:0] fullCyc   = oneCyc * `ASP_SETTLE_FACTOR;
  wire [7:0]  statusByte = {rdyN, 3'h0, dataChan};
  wire [2:0]  cmdRs     = cmdReg[`ASP_CMD_RS_HI:`ASP_CMD_RS_LO];
  wire [7:0]  cmdNow    = {inShift[6:0], dinBit};

  wire [23:0] fifoData;
  wire        fifoValid;
  wire        fifoPop = ce & rst_n & ~ifReset & ~restartReq & (cvState == CV_TAKE);

  // ==================================================
  // helpers
  function [3:0] firstChan;
    input [7:0] m;
    integer i;
    begin
      firstChan = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (m[i]) begin
          firstChan = i[3:0];
        end
      end
    end
  endfunction

  function [3:0] nextChan;
    input [7:0] m;
    input [3:0] c;
    integer i;
    begin
      nextChan = firstChan(m);
      for (i = 7; i >= 0; i = i - 1) begin
        if (m[i] && (i > c)) begin
          nextChan = i[3:0];
        end
      end
    end
  endfunction

  function [5:0] regLen;
    input [2:0] rs;
    input       app;
    begin
      case (rs)
        `ASP_RS_MODE:   regLen = `ASP_LEN_WORD;
        `ASP_RS_CONFIG: regLen = `ASP_LEN_WORD;
        `ASP_RS_DATA:   regLen = app ? `ASP_LEN_WORD_STAT : `ASP_LEN_WORD;
        default:        regLen = `ASP_LEN_BYTE;
      endcase
    end
  endfunction

  // read value left aligned so the MSB leaves first
  function [31:0] readVal;
    input [2:0] rs;
    begin
      case (rs)
        `ASP_RS_STATUS: readVal = {statusByte, 24'h000000};
        `ASP_RS_MODE:   readVal = {modeWord, 8'h00};
        `ASP_RS_CONFIG: readVal = {configWord, 8'h00};
        `ASP_RS_DATA:   readVal = {dataReg, appendSel ? statusByte : 8'h00};
        `ASP_RS_ID:     readVal = {ID_CODE, 24'h000000};
        default:        readVal = 32'h00000000;
      endcase
    end
  endfunction

  // ==================================================
  // serial port and conversion sequencer
  always @(posedge clk) begin
    if (!rst_n || ifReset) begin
      spState       <= SP_CMD;
      cmdReg        <= 8'h00;
      inShift       <= 24'h000000;
      bitCnt        <= 6'h00;
      outShift      <= 32'h00000000;
      outLen        <= 6'h00;
      outCnt        <= 6'h00;
      curBit        <= 1'b1;
      shifting      <= 1'b0;
      onesCnt       <= 6'h00;
      ifReset       <= 1'b0;
      creadWin      <= 8'h00;
      rdyN          <= 1'b1;
      dataReg       <= 24'h000000;
      dataChan      <= 4'h0;
      modeWord      <= `ASP_MODE_RESET;
      configWord    <= `ASP_CONF_RESET;
      cvState       <= CV_OFF;
      cvCnt         <= 32'h00000000;
      pendWord      <= 24'h000000;
      pendDrop      <= 1'b0;
      restartReq    <= 1'b1;
      activeChannel <= 4'h0;
      filterReset   <= 1'b0;
      powerDown     <= 1'b1;
      doutRdy       <= 1'b1;
      doutOe        <= 1'b0;
    end else if (ce) begin
      filterReset <= 1'b0;
      // line is driven only while selected, so ready shows only with cs low
      doutOe  <= csLow;
      doutRdy <= (shifting && outCnt != 6'h00) ? curBit : rdyN;

      // ---------- run of ones on data-in
      if (sRise) begin
        if (!dinBit) begin
          onesCnt <= 6'h00;
        end else if (onesCnt == `ASP_IFRESET_ONES - 6'h01) begin
          ifReset <= 1'b1;
        end else begin
          onesCnt <= onesCnt + 6'h01;
        end
      end

      // ---------- output bit shifting on falling edges
      if (shifting && outCnt < outLen && (sFall || (csFall && outCnt == 6'h00))) begin
        curBit   <= outShift[31];
        outShift <= {outShift[30:0], 1'b0};
        outCnt   <= outCnt + 6'h01;
      end

      // ---------- input sampling on rising edges
      if (sRise) begin
        case (spState)
          SP_CMD: begin
            inShift <= {inShift[22:0], dinBit};
            bitCnt  <= bitCnt + 6'h01;
            if (bitCnt == 6'h07) begin
              bitCnt <= 6'h00;
              // a byte with the top bit set is not a command and is ignored
              if (!cmdNow[`ASP_CMD_WEN_BIT]) begin
                cmdReg <= cmdNow;
                outLen <= regLen(cmdNow[`ASP_CMD_RS_HI:`ASP_CMD_RS_LO], appendSel);
                outCnt <= 6'h00;
                if (cmdNow == `ASP_CMD_CREAD_ENTER) begin
                  spState  <= SP_CREAD;
                  creadWin <= 8'h00;
                end else if (cmdNow[`ASP_CMD_RW_BIT]) begin
                  spState  <= SP_READ;
                  outShift <= readVal(cmdNow[`ASP_CMD_RS_HI:`ASP_CMD_RS_LO]);
                  shifting <= 1'b1;
                end else begin
                  spState <= SP_WRITE;
                end
              end
            end
          end
          SP_WRITE: begin
            inShift <= {inShift[22:0], dinBit};
            bitCnt  <= bitCnt + 6'h01;
            if (bitCnt == outLen - 6'h01) begin
              bitCnt  <= 6'h00;
              spState <= SP_CMD;
              if (cmdRs == `ASP_RS_MODE) begin
                modeWord   <= {inShift[22:0], dinBit};
                restartReq <= 1'b1;
              end else if (cmdRs == `ASP_RS_CONFIG) begin
                configWord <= {inShift[22:0], dinBit};
                restartReq <= 1'b1;
              end
            end
          end
          SP_READ: begin
            bitCnt <= bitCnt + 6'h01;
            if (bitCnt == outLen - 6'h01) begin
              bitCnt   <= 6'h00;
              shifting <= 1'b0;
              spState  <= SP_CMD;
              // the word stays in the data register for another read
              if (cmdRs == `ASP_RS_DATA) begin
                rdyN <= 1'b1;
              end
            end
          end
          SP_CREAD: begin
            creadWin <= {creadWin[6:0], dinBit};
            if ({creadWin[6:0], dinBit} == `ASP_CMD_CREAD_EXIT && !rdyN) begin
              spState  <= SP_CMD;
              shifting <= 1'b0;
              bitCnt   <= 6'h00;
            end else if (shifting) begin
              bitCnt <= bitCnt + 6'h01;
              if (bitCnt == outLen - 6'h01) begin
                bitCnt   <= 6'h00;
                shifting <= 1'b0;
                rdyN     <= 1'b1;
              end
            end
          end
          default: spState <= SP_CMD;
        endcase
      end

      // ---------- conversion sequencer
      if (restartReq) begin
        restartReq    <= 1'b0;
        activeChannel <= firstChan(chMask);
        filterReset   <= 1'b1;
        rdyN          <= 1'b1;
        cvCnt         <= fullCyc;
        if (chMask == 8'h00) begin
          cvState   <= CV_OFF;
          powerDown <= 1'b1;
        end else if (opMode == `ASP_MD_CONT) begin
          cvState   <= CV_SETTLE;
          powerDown <= 1'b0;
        end else if (opMode == `ASP_MD_SINGLE) begin
          cvState   <= CV_WAKE;
          cvCnt     <= STARTUP_CYCLES;
          powerDown <= 1'b0;
        end else begin
          cvState   <= CV_OFF;
          powerDown <= 1'b1;
        end
      end else begin
        case (cvState)
          CV_OFF: begin
            cvCnt <= 32'h00000000;
          end
          CV_WAKE: begin
            if (cvCnt <= 32'h00000001) begin
              cvState     <= CV_SETTLE;
              cvCnt       <= fullCyc;
              filterReset <= 1'b1;
            end else begin
              cvCnt <= cvCnt - 32'h00000001;
            end
          end
          CV_SETTLE: begin
            if (cvCnt <= 32'h00000001) begin
              cvState <= CV_TAKE;
            end else begin
              cvCnt <= cvCnt - 32'h00000001;
            end
          end
          CV_TAKE: begin
            // stalls here until the filter has a word, back-pressuring nothing else
            if (fifoValid) begin
              pendWord <= fifoData;
              cvState  <= CV_UPD;
              if (spState == SP_READ && cmdRs == `ASP_RS_DATA) begin
                pendDrop <= 1'b1;
              end else begin
                pendDrop <= 1'b0;
                rdyN     <= 1'b1;
              end
            end
          end
          CV_UPD: begin
            if (!pendDrop) begin
              dataReg  <= pendWord;
              dataChan <= activeChannel;
              rdyN     <= 1'b0;
              if (spState == SP_CREAD) begin
                // any partly clocked word is thrown away here
                outShift <= {pendWord, appendSel ? {4'h0, activeChannel} : 8'h00};
                outLen   <= regLen(`ASP_RS_DATA, appendSel);
                outCnt   <= 6'h00;
                bitCnt   <= 6'h00;
                shifting <= 1'b1;
              end
            end
            if (opMode == `ASP_MD_SINGLE &&
                nextChan(chMask, activeChannel) <= activeChannel) begin
              modeWord[`ASP_MODE_MD_HI:`ASP_MODE_MD_LO] <= `ASP_MD_PDOWN;
              cvState   <= CV_OFF;
              powerDown <= 1'b1;
            end else if (nextChan(chMask, activeChannel) != activeChannel) begin
              activeChannel <= nextChan(chMask, activeChannel);
              filterReset   <= 1'b1;
              cvCnt         <= fullCyc;
              cvState       <= CV_SETTLE;
            end else begin
              cvCnt   <= zeroLat ? fullCyc : oneCyc;
              cvState <= CV_SETTLE;
            end
          end
          default: cvState <= CV_OFF;
        endcase
      end
    end
  end

  // ==================================================
  // filter output buffer
  asp_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

endmodule

`default_nettype wire

// ===== bench/asp_core_monitor.sv
// concurrent checks on the ports of the serial port and sequencer
`timescale 1ns/1ns
`default_nettype none
module asp_core_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        csN,
  input wire logic        sampleValid,
  input wire logic        sampleReady,
  input wire logic        doutRdy,
  input wire logic        doutOe,
  input wire logic [23:0] modeWord,
  input wire logic [23:0] configWord,
  input wire logic [3:0]  activeChannel,
  input wire logic        filterReset,
  input wire logic        powerDown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // sequences
  sequence s_cs_low;
    !csN [*5];
  endsequence
  sequence s_cs_high;
    csN [*4];
  endsequence
  // ==================================================
  // properties
  a_reset_values: assert property ($rose(rst_n) |-> modeWord == 24'h000060
    && configWord == 24'h000100 && doutRdy && !doutOe) else $error("bad reset values");
  // an interface reset may drop the enable for one cycle
  a_oe_on_cs: assert property (s_cs_low |-> ##[1:2] doutOe)
    else $error("output not enabled with select low");
  a_oe_off_cs: assert property (s_cs_high |=> !doutOe)
    else $error("output enabled with select high");
  a_filter_pulse: assert property (filterReset |=> !filterReset)
    else $error("filter reset longer than one cycle");
  a_full_by_push: assert property ($fell(sampleReady) |-> $past(sampleValid))
    else $error("fifo filled without a push");
  a_ready_kept: assert property (sampleReady && !sampleValid |=> sampleReady)
    else $error("fifo ready dropped without a push");
  a_chan_enabled: assert property ($changed(activeChannel)
    |-> configWord[{1'b0, activeChannel} + 5'h08]) else $error("disabled channel selected");
  a_pd_after_single: assert property ($rose(powerDown) && modeWord != 24'h000060
    |-> ##[0:1] modeWord[23:21] == 3'h3) else $error("power down without mode change");
  a_wake_mode: assert property ($fell(powerDown) |-> modeWord[23:21] != 3'h3)
    else $error("woke up in power down mode");
endmodule
`default_nettype wire

// ===== bench/asp_host_model.sv
// host serial port model: idles the serial clock high, frames by select
`timescale 1ns/1ns
`default_nettype none
module asp_host_model (
  output var logic csN,
  output var logic sclk,
  output var logic din,
  input  wire logic doutRdy,
  input  wire logic doutOe
);
  // ==================================================
  // link tasks
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  task automatic setCs(input logic lvl);
    csN = lvl;
    #63;
  endtask
  // undriven line reads as the inverse of the last bit, never a lucky match
  task automatic shift(input int n, input logic [63:0] tx, output logic [63:0] rx);
    int i;
    rx = 64'h0;
    for (i = n - 1; i >= 0; i--) begin
      #62 sclk = 1'b0;
      din = tx[i];
      #63 sclk = 1'b1;
      rx = {rx[62:0], doutOe ? doutRdy : ~rx[0]};
    end
    #62 din = 1'b0;
  endtask
  task automatic ifReset();
    logic [63:0] rx;
    shift(40, {64{1'b1}}, rx);
    #500000;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_asp_core.sv
// self-checking bench of the serial port and conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_asp_core;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [23:0] sampleData = 24'h000000;
  logic        sampleValid = 1'b0;
  wire         csN, sclk, din, sampleReady, doutRdy, doutOe, filterReset, powerDown;
  wire  [23:0] modeWord, configWord;
  wire  [3:0]  activeChannel;
  int          failures = 0;
  int          n_tests = 0;
  logic [63:0] rx;
  always #5 clk = ~clk;
  asp_core #(.STARTUP_CYCLES(32'd20), .RATE_UNIT(32'd1)) u_dut (.clk(clk), .rst_n(rst_n),
    .ce(ce), .csN(csN), .sclk(sclk), .din(din), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .doutRdy(doutRdy), .doutOe(doutOe),
    .modeWord(modeWord), .configWord(configWord), .activeChannel(activeChannel),
    .filterReset(filterReset), .powerDown(powerDown));
  asp_host_model u_host (.csN(csN), .sclk(sclk), .din(din), .doutRdy(doutRdy),
    .doutOe(doutOe));
  // ==================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic writeReg(input logic [7:0] cmd, input logic [23:0] val);
    u_host.shift(32, {32'h0, cmd, val}, rx);
  endtask
  task automatic readData(input int n);
    u_host.shift(8 + n, {56'h0, 8'h58} << n, rx);
  endtask
  task automatic push(input logic [23:0] d);
    @(negedge clk);
    sampleData = d;
    sampleValid = 1'b1;
    @(negedge clk);
    check("fifo ready", {31'h0, sampleReady}, 32'h1);
    sampleValid = 1'b0;
  endtask
  // sel 0 waits for a new word on the line, sel 1 for power down
  task automatic waitUntil(input int sel);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (sel == 0 ? doutRdy === 1'b0 : powerDown === 1'b1) return;
    end
    check("wait bound", 32'h1, 32'h0);
    summarize();
  endtask
  // ==================================================
  // scenarios
  task automatic scResetValues();
    check("mode reset", {8'h0, modeWord}, 32'h000060);
    check("config reset", {8'h0, configWord}, 32'h000100);
  endtask
  task automatic scReadTwice();
    u_host.setCs(1'b0);
    writeReg(8'h08, 24'h000002);
    check("mode write", {8'h0, modeWord}, 32'h000002);
    push(24'hA5C3E1);
    waitUntil(0);
    readData(24);
    check("data word", {8'h0, rx[23:0]}, 32'hA5C3E1);
    repeat (10) @(negedge clk);
    check("ready after read", {31'h0, doutRdy}, 32'h1);
    readData(24);
    check("data again", {8'h0, rx[23:0]}, 32'hA5C3E1);
    u_host.setCs(1'b1);
  endtask
  task automatic scAppend();
    u_host.setCs(1'b0);
    writeReg(8'h08, 24'h100002);
    writeReg(8'h10, 24'h000300);
    push(24'h3C5A96);
    waitUntil(0);
    readData(32);
    check("word ch0", {8'h0, rx[31:8]}, 32'h3C5A96);
    check("chan ch0", {28'h0, rx[3:0]}, 32'h0);
    push(24'hC0FFE1);
    waitUntil(0);
    readData(32);
    check("word ch1", {8'h0, rx[31:8]}, 32'hC0FFE1);
    check("chan ch1", {28'h0, rx[3:0]}, 32'h1);
  endtask
  task automatic scContRead();
    u_host.shift(8, 64'h5C, rx);
    push(24'h7E1829);
    waitUntil(0);
    u_host.shift(32, 64'h0, rx);
    check("cread word", {8'h0, rx[31:8]}, 32'h7E1829);
    check("cread status", {24'h0, rx[7:0]}, 32'h0);
    push(24'h19E2D4);
    waitUntil(0);
    u_host.shift(8, 64'h58, rx);
    readData(32);
    check("word after exit", {8'h0, rx[31:8]}, 32'h19E2D4);
  endtask
  task automatic scIfReset();
    u_host.ifReset();
    check("mode after ones", {8'h0, modeWord}, 32'h000060);
    check("config after ones", {8'h0, configWord}, 32'h000100);
    u_host.setCs(1'b1);
  endtask
  task automatic scSingle();
    u_host.setCs(1'b0);
    writeReg(8'h08, 24'h200002);
    push(24'h5AA5F0);
    waitUntil(0);
    waitUntil(1);
    check("mode after single", {29'h0, modeWord[23:21]}, 32'h3);
    readData(24);
    check("single word", {8'h0, rx[23:0]}, 32'h5AA5F0);
    repeat (10) @(negedge clk);
    check("ready stays high", {31'h0, doutRdy}, 32'h1);
    u_host.setCs(1'b1);
  endtask
  // serial edges while frozen must be lost, then a reset in mid-run
  task automatic scFreeze();
    u_host.setCs(1'b0);
    @(negedge clk);
    ce = 1'b0;
    writeReg(8'h08, 24'h000002);
    check("frozen mode", {29'h0, modeWord[23:21]}, 32'h3);
    check("frozen ready", {31'h0, doutRdy}, 32'h1);
    @(negedge clk);
    ce = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check("mode mid reset", {8'h0, modeWord}, 32'h000060);
    check("power after reset", {31'h0, powerDown}, 32'h1);
    writeReg(8'h08, 24'h000002);
    check("first write after reset", {8'h0, modeWord}, 32'h000002);
    u_host.setCs(1'b1);
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    scResetValues();
    scReadTwice();
    scAppend();
    scContRead();
    scIfReset();
    scSingle();
    scFreeze();
    summarize();
  end
endmodule
bind asp_core asp_core_monitor u_mon (.clk(clk), .rst_n(rst_n), .csN(csN),
  .sampleValid(sampleValid), .sampleReady(sampleReady), .doutRdy(doutRdy), .doutOe(doutOe),
  .modeWord(modeWord), .configWord(configWord), .activeChannel(activeChannel),
  .filterReset(filterReset), .powerDown(powerDown));
`default_nettype wire
